/* arct_params.svh */
// Constants of the auto-reload capture timer: offsets, field positions, resets, counts.
// Assumes the includer wants only macros; no logic lives here.
// Notes on behaviour
// [RL1] Counter is two byte registers, one count.
// [RL2] Split selects one 16-bit or two 8-bit counters.
// [RL3] 16-bit wrap loads reload pair, sets high flag.
// [RL4] Timer interrupt enabled: request on each overflow.
// [RL5] Low irq enable adds request on low wrap.
// [RL6] Split: each byte reloads from own reload.
// [RL7] Split: run gates high byte only.
// [RL8] Fast bit picks system clock, else select table.
// [RL9] Comparator and external clock synchronised before use.
// [RL10] Split: each byte wrap sets its flag.
// [RL11] Split: high wrap requests, low if enabled.
// [RL12] Flags cleared only by software writes.
// [RL13] Capture enable selects capture mode, keep unsplit.
// [RL14] Capture on comparator edge or eight ext clocks.
// [RL15] Capture copies count to reload, sets flag.
// [RL16] Control register at index 0x91, resets zero.
// [RL17] 16-bit counts only when run; capture wraps free.
// [RL18] Writes act next edge; hardware set beats clear.
`ifndef ARCT_PARAMS_SVH
`define ARCT_PARAMS_SVH

`define ARCT_ADDR_W 12
`define ARCT_CTL_IDX 12'h091
`define ARCT_CTL_ADDR 12'h244
`define ARCT_CNT_LO_ADDR 12'h000
`define ARCT_CNT_HI_ADDR 12'h004
`define ARCT_RLD_LO_ADDR 12'h008
`define ARCT_RLD_HI_ADDR 12'h00c
`define ARCT_CLK_CTL_ADDR 12'h010
`define ARCT_IRQ_EN_ADDR 12'h014
`define ARCT_IRQ_STAT_ADDR 12'h018
`define ARCT_IRQ_MASK_ADDR 12'h01c

`define ARCT_CTL_RESET 8'h00
`define ARCT_IRQ_EN_BIT 7
`define ARCT_LO_FAST_BIT 0
`define ARCT_HI_FAST_BIT 1
`define ARCT_STAT_HI_BIT 0
`define ARCT_STAT_LO_BIT 1

`define ARCT_DIV12_LAST 4'hb
`define ARCT_DIV8_LAST 3'h7

`define ARCT_RESP_OKAY 2'h0
`define ARCT_RESP_SLVERR 2'h2

`endif

/* arct_pkg.sv */
// Types shared by the auto-reload capture timer.
// Assumes arct_params.svh supplies all numbers.
package arct_pkg;

  // Control byte, bit 7 first
  typedef struct packed {
    logic hi_flag;
    logic lo_flag;
    logic low_irq_en;
    logic cap_en;
    logic split;
    logic run;
    logic [1:0] ext_sel;
  } arct_ctl_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } arct_word_type;

endpackage

/* arct_timer.sv */
// Auto-reload capture timer with an AXI4-Lite register slave and one level interrupt.
// Assumes comparator and external oscillator inputs are asynchronous to aclk.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`include "arct_params.svh"

module arct_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`ARCT_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`ARCT_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Asynchronous count sources
  input wire logic cmp1_in,
  input wire logic ext_osc_in,
  // Interrupt
  output logic irq
);

  // Bus state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic aw_have_q, w_have_q;
  logic [`ARCT_ADDR_W-1:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;

  // Timer state
  arct_pkg::arct_ctl_type ctl_q, ctl_d;
  arct_pkg::arct_word_type cnt_q, cnt_d, rld_q, rld_d;
  logic [1:0] clk_ctl_q;
  logic [7:0] irq_en_q;
  logic [1:0] stat_q, stat_d, mask_q;

  // Synchronisers and prescalers
  logic cmp_s1_q, cmp_s2_q, cmp_s3_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [3:0] div12_q;
  logic [2:0] div8_q;

  // Write decode
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire wr_en = wr_go && wstrb0_q;
  wire wr_ctl = wr_en && (waddr_q == `ARCT_CTL_ADDR);
  wire wr_cnt_lo = wr_en && (waddr_q == `ARCT_CNT_LO_ADDR);
  wire wr_cnt_hi = wr_en && (waddr_q == `ARCT_CNT_HI_ADDR);
  wire wr_rld_lo = wr_en && (waddr_q == `ARCT_RLD_LO_ADDR);
  wire wr_rld_hi = wr_en && (waddr_q == `ARCT_RLD_HI_ADDR);
  wire wr_clk = wr_en && (waddr_q == `ARCT_CLK_CTL_ADDR);
  wire wr_irq_en = wr_en && (waddr_q == `ARCT_IRQ_EN_ADDR);
  wire wr_stat = wr_en && (waddr_q == `ARCT_IRQ_STAT_ADDR);
  wire wr_mask = wr_en && (waddr_q == `ARCT_IRQ_MASK_ADDR);
  wire w_mapped = (waddr_q == `ARCT_CTL_ADDR) || (waddr_q == `ARCT_CNT_LO_ADDR) ||
                  (waddr_q == `ARCT_CNT_HI_ADDR) || (waddr_q == `ARCT_RLD_LO_ADDR) ||
                  (waddr_q == `ARCT_RLD_HI_ADDR) || (waddr_q == `ARCT_CLK_CTL_ADDR) ||
                  (waddr_q == `ARCT_IRQ_EN_ADDR) || (waddr_q == `ARCT_IRQ_STAT_ADDR) ||
                  (waddr_q == `ARCT_IRQ_MASK_ADDR);

  // Read decode
  wire rd_take = arvalid && arready_q;
  wire r_mapped = (araddr == `ARCT_CTL_ADDR) || (araddr == `ARCT_CNT_LO_ADDR) ||
                  (araddr == `ARCT_CNT_HI_ADDR) || (araddr == `ARCT_RLD_LO_ADDR) ||
                  (araddr == `ARCT_RLD_HI_ADDR) || (araddr == `ARCT_CLK_CTL_ADDR) ||
                  (araddr == `ARCT_IRQ_EN_ADDR) || (araddr == `ARCT_IRQ_STAT_ADDR) ||
                  (araddr == `ARCT_IRQ_MASK_ADDR);
  wire [7:0] rd_byte =
    (araddr == `ARCT_CTL_ADDR) ? ctl_q :
    (araddr == `ARCT_CNT_LO_ADDR) ? cnt_q.lo :
    (araddr == `ARCT_CNT_HI_ADDR) ? cnt_q.hi :
    (araddr == `ARCT_RLD_LO_ADDR) ? rld_q.lo :
    (araddr == `ARCT_RLD_HI_ADDR) ? rld_q.hi :
    (araddr == `ARCT_CLK_CTL_ADDR) ? {6'h00, clk_ctl_q} :
    (araddr == `ARCT_IRQ_EN_ADDR) ? irq_en_q :
    (araddr == `ARCT_IRQ_STAT_ADDR) ? {6'h00, stat_q} :
    (araddr == `ARCT_IRQ_MASK_ADDR) ? {6'h00, mask_q} : 8'h00;

  // Source ticks; only the second and third stages feed logic [RL9]
  wire cmp_rise = cmp_s2_q && !cmp_s3_q;
  wire ext_rise = ext_s2_q && !ext_s3_q;
  wire div12_tick = (div12_q == `ARCT_DIV12_LAST);
  wire ext8_tick = ext_rise && (div8_q == `ARCT_DIV8_LAST);
  wire ext_tick = (ctl_q.ext_sel == 2'h1) ? ext8_tick :
                  (ctl_q.ext_sel == 2'h3) ? cmp_rise : div12_tick; // [RL8]
  wire [1:0] tick;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tick
      assign tick[g] = clk_ctl_q[g] ? 1'b1 : ext_tick; // [RL8]
    end
  endgenerate

  // Capture trigger: upper select bit low picks the comparator [RL14]
  wire cap_ev = ctl_q.cap_en && (ctl_q.ext_sel[1] ? ext8_tick : cmp_rise);

  // Counting terms
  wire mode16 = !ctl_q.split || ctl_q.cap_en;
  wire step16 = mode16 && ctl_q.run && tick[`ARCT_LO_FAST_BIT]; // [RL17]
  wire wrap16 = step16 && (cnt_q == 16'hffff);
  wire step_lo = ctl_q.split && !ctl_q.cap_en && tick[`ARCT_LO_FAST_BIT]; // [RL7]
  wire step_hi = ctl_q.split && !ctl_q.cap_en && ctl_q.run && tick[`ARCT_HI_FAST_BIT];
  wire wrap_lo = (step16 || step_lo) && (cnt_q.lo == 8'hff);
  wire wrap_hi8 = step_hi && (cnt_q.hi == 8'hff);
  wire hi_ev = wrap16 || wrap_hi8 || cap_ev; // [RL3] [RL10] [RL15]
  wire tmr_irq_on = irq_en_q[`ARCT_IRQ_EN_BIT];
  wire req_hi = hi_ev && tmr_irq_on; // [RL4] [RL11]
  wire req_lo = wrap_lo && tmr_irq_on && ctl_q.low_irq_en; // [RL5] [RL11]

  // Counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (step16) begin
      if (cnt_q == 16'hffff) begin
        cnt_d = ctl_q.cap_en ? 16'h0000 : rld_q; // [RL3] [RL17]
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end else begin
      if (step_lo) begin
        cnt_d.lo = (cnt_q.lo == 8'hff) ? rld_q.lo : cnt_q.lo + 8'h01; // [RL6]
      end
      if (step_hi) begin
        cnt_d.hi = (cnt_q.hi == 8'hff) ? rld_q.hi : cnt_q.hi + 8'h01; // [RL6]
      end
    end
    // Software writes override the count in the same edge [RL18]
    if (wr_cnt_lo) begin
      cnt_d.lo = wbyte_q;
    end
    if (wr_cnt_hi) begin
      cnt_d.hi = wbyte_q;
    end
  end

  // Reload, control and status next values
  always_comb begin
    rld_d = rld_q;
    if (cap_ev) begin
      rld_d = cnt_q; // [RL15]
    end
    if (wr_rld_lo) begin
      rld_d.lo = wbyte_q;
    end
    if (wr_rld_hi) begin
      rld_d.hi = wbyte_q;
    end
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = arct_pkg::arct_ctl_type'(wbyte_q); // [RL13]
    end
    // Hardware set wins over a clearing write; no hardware clear [RL12] [RL18]
    ctl_d.hi_flag = ctl_d.hi_flag || hi_ev;
    ctl_d.lo_flag = ctl_d.lo_flag || wrap_lo; // [RL10]
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wbyte_q[1:0];
    end
    stat_d[`ARCT_STAT_HI_BIT] = stat_d[`ARCT_STAT_HI_BIT] || req_hi;
    stat_d[`ARCT_STAT_LO_BIT] = stat_d[`ARCT_STAT_LO_BIT] || req_lo;
  end

  // Timer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= `ARCT_CTL_RESET; // [RL16]
      cnt_q <= 16'h0000;
      rld_q <= 16'h0000;
      clk_ctl_q <= 2'h0;
      irq_en_q <= 8'h00;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      cnt_q <= cnt_d; // [RL1] [RL2]
      rld_q <= rld_d;
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
      if (wr_clk) begin
        clk_ctl_q <= wbyte_q[1:0];
      end
      if (wr_irq_en) begin
        irq_en_q <= wbyte_q;
      end
      if (wr_mask) begin
        mask_q <= wbyte_q[1:0];
      end
    end
  end

  // Synchronisers and prescalers [RL9]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cmp_s1_q, cmp_s2_q, cmp_s3_q} <= 3'h0;
      {ext_s1_q, ext_s2_q, ext_s3_q} <= 3'h0;
      div12_q <= 4'h0;
      div8_q <= 3'h0;
    end else begin
      {cmp_s1_q, cmp_s2_q, cmp_s3_q} <= {cmp1_in, cmp_s1_q, cmp_s2_q};
      {ext_s1_q, ext_s2_q, ext_s3_q} <= {ext_osc_in, ext_s1_q, ext_s2_q};
      div12_q <= div12_tick ? 4'h0 : div12_q + 4'h1;
      if (ext_rise) begin
        div8_q <= div8_q + 3'h1;
      end
    end
  end

  // Write channel: address and data taken in either order, one write at a time.
  // Ready drops once a beat is held so a second beat cannot overwrite it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ARCT_RESP_OKAY;
    end else begin
      awready_q <= !aw_have_q && !(awvalid && awready_q) && !bvalid_q && !wr_go;
      wready_q <= !w_have_q && !(wvalid && wready_q) && !bvalid_q && !wr_go;
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? `ARCT_RESP_OKAY : `ARCT_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answer one edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ARCT_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !rd_take;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= r_mapped ? `ARCT_RESP_OKAY : `ARCT_RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_high_flag_set: assert property (hi_ev |=> ctl_q.hi_flag) // [RL3]
    else $error("high flag not set after overflow or capture");
  chk_low_flag_set: assert property (wrap_lo |=> ctl_q.lo_flag) // [RL10]
    else $error("low flag not set after low byte wrap");
  chk_reload_sixteen: assert property (wrap16 && !ctl_q.cap_en && !wr_en // [RL3]
      |=> cnt_q == $past(rld_q))
    else $error("16-bit wrap did not load reload value");
  chk_capture_free_wrap: assert property (wrap16 && ctl_q.cap_en && !wr_en // [RL17]
      |=> cnt_q == 16'h0000)
    else $error("capture mode counter did not wrap to zero");
  chk_split_low_runs: assert property (ctl_q.split && !ctl_q.cap_en && !ctl_q.run && // [RL7]
      tick[0] && cnt_q.lo != 8'hff && !wr_en |=> cnt_q.lo == $past(cnt_q.lo) + 8'h01)
    else $error("low byte stalled in split mode");
  chk_split_high_held: assert property (ctl_q.split && !ctl_q.run && !wr_en // [RL7]
      |=> $stable(cnt_q.hi))
    else $error("high byte moved with run clear");
  chk_capture_copy: assert property (cap_ev && !wr_en |=> rld_q == $past(cnt_q)) // [RL15]
    else $error("capture did not copy count to reload");
  chk_flag_sticky: assert property (ctl_q.hi_flag && !wr_ctl |=> ctl_q.hi_flag) // [RL12]
    else $error("high flag cleared without a write");
  chk_irq_request: assert property (req_hi && mask_q[0] && !wr_mask |=> irq) // [RL4]
    else $error("unmasked overflow raised no interrupt");
  chk_comp_sync: assert property (cmp_rise |-> $past(cmp1_in, 2) && !$past(cmp1_in, 3)) // [RL9]
    else $error("comparator edge not two stages late");
  // Eleven quiet cycles, split because a repetition stays at eight or fewer
  chk_div_twelve: assert property (div12_tick // [RL8]
      |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("system clock prescaler period wrong");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");

  // Interrupt requests and status
  chk_high_req: assert property (req_hi |=> stat_q[`ARCT_STAT_HI_BIT]) // [RL4] [RL11]
    else $error("high event did not set its status bit");
  chk_low_req: assert property (req_lo |=> stat_q[`ARCT_STAT_LO_BIT]) // [RL5] [RL11]
    else $error("low wrap did not set its status bit");
  chk_irq_gate: assert property (hi_ev && !tmr_irq_on && !stat_q[`ARCT_STAT_HI_BIT] // [RL4]
      |=> !stat_q[`ARCT_STAT_HI_BIT])
    else $error("high request raised with timer interrupts off");
  chk_stat_sticky: assert property (stat_q[`ARCT_STAT_HI_BIT] && !wr_stat // [RL12]
      |=> stat_q[`ARCT_STAT_HI_BIT])
    else $error("high status bit cleared without a write");
  chk_masked_quiet: assert property (mask_q == 2'h0 |=> !irq)
    else $error("interrupt raised with every source masked");

  // Split reloads, run gating and the fast clock
  chk_split_low_reload: assert property (step_lo && cnt_q.lo == 8'hff && !wr_en // [RL6]
      |=> cnt_q.lo == $past(rld_q.lo))
    else $error("low byte did not reload from its own reload");
  chk_split_high_reload: assert property (step_hi && cnt_q.hi == 8'hff && !wr_en // [RL6]
      |=> cnt_q.hi == $past(rld_q.hi))
    else $error("high byte did not reload from its own reload");
  chk_split_high_step: assert property (step_hi && cnt_q.hi != 8'hff && !wr_en // [RL7]
      |=> cnt_q.hi == $past(cnt_q.hi) + 8'h01)
    else $error("running high byte did not step");
  chk_run_gates_sixteen: assert property (mode16 && !ctl_q.run && !wr_en // [RL17]
      |=> $stable(cnt_q))
    else $error("16-bit counter moved with run clear");
  chk_fast_step: assert property (clk_ctl_q[0] && mode16 && ctl_q.run && // [RL8]
      cnt_q != 16'hffff && !wr_en |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("fast clock did not step every cycle");

  // Bus handshakes
  chk_write_answer: assert property (wr_go |=> bvalid)
    else $error("write response not one cycle after both beats");
  chk_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready while a response is pending");
  chk_read_answer: assert property (rd_take
      |=> rvalid && rdata[31:8] == 24'h00_0000)
    else $error("read answer late or upper bits not zero");
  chk_read_hold: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before rready");

  cov_capture: cover property (cap_ev);
  cov_split_low_wrap: cover property (ctl_q.split && wrap_lo);
  cov_reload_sixteen: cover property (wrap16 && !ctl_q.cap_en);
  cov_irq: cover property (irq);
  cov_ext_capture: cover property (cap_ev && ctl_q.ext_sel[1]);

endmodule

/* tb_arct_timer.sv */
// Self-checking bench for the auto-reload capture timer, driven over AXI4-Lite.
// Assumes arct_params.svh and arct_timer are compiled alongside; one clock, aclk.
`include "arct_params.svh"

module tb_arct_timer;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] CTL = `ARCT_CTL_ADDR;
  localparam logic [11:0] CLO = `ARCT_CNT_LO_ADDR;
  localparam logic [11:0] CHI = `ARCT_CNT_HI_ADDR;
  localparam logic [11:0] RLO = `ARCT_RLD_LO_ADDR;
  localparam logic [11:0] RHI = `ARCT_RLD_HI_ADDR;
  localparam logic [11:0] CKC = `ARCT_CLK_CTL_ADDR;
  localparam logic [11:0] IEN = `ARCT_IRQ_EN_ADDR;
  localparam logic [11:0] STA = `ARCT_IRQ_STAT_ADDR;
  localparam logic [11:0] MSK = `ARCT_IRQ_MASK_ADDR;

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cmp1_in, ext_osc_in;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bs, rs;
  logic [7:0] rl, rh;
  int err_total, check_count;

  arct_timer u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .cmp1_in(cmp1_in), .ext_osc_in(ext_osc_in), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Range test for values that depend on prescaler phase or sync latency
  function automatic logic [31:0] inr(input logic [31:0] v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && !awvalid && !wvalid) begin
        bs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    err_total++;
    wrap_up();
  endtask

  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && !arvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    err_total++;
    wrap_up();
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 400; i++) begin
      @(posedge aclk);
      if (irq === 1'b1) return;
    end
    err_total++;
    wrap_up();
  endtask

  // Slow pulses so every edge survives the three-stage synchroniser
  task automatic pulses(input bit on_cmp, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (on_cmp) cmp1_in <= 1'b1;
      else ext_osc_in <= 1'b1;
      repeat (3) @(posedge aclk);
      cmp1_in <= 1'b0;
      ext_osc_in <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask

  initial begin
    logic [11:0] regs [5];
    logic [7:0] sel;
    int n;
    regs = '{CTL, CLO, CHI, RLO, RHI};
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cmp1_in, ext_osc_in} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    void'($urandom(32'h9b86));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) begin
      rdr(regs[i]);
      chk(rd, 32'h0);
      chk(rs, `ARCT_RESP_OKAY);
    end
    chk(irq, 1'b0);
    rdr(12'h020);
    chk(rd, 32'h0);
    chk(rs, `ARCT_RESP_SLVERR);
    wr(12'h024, 8'hff);
    chk(bs, `ARCT_RESP_SLVERR);
    // Write with the low byte lane off: answered but not stored
    wstrb <= 4'h0;
    wr(RLO, 8'h5a);
    wstrb <= 4'hf;
    chk(bs, `ARCT_RESP_OKAY);
    rdr(RLO);
    chk(rd, 32'h0);
    // 16-bit wrap with reload, both requests
    wr(IEN, 8'h80);
    wr(MSK, 8'h03);
    wr(CKC, 8'h01);
    rl = 8'($urandom_range(0, 63));
    rh = 8'($urandom);
    wr(RLO, rl);
    wr(RHI, rh);
    wr(CHI, 8'hff);
    wr(CLO, 8'hf0);
    wr(CTL, 8'h24);
    wait_irq();
    wr(CTL, 8'hc0);
    rdr(CTL);
    chk(rd, 32'hc0);
    rdr(STA);
    chk(rd, 32'h3);
    rdr(CHI);
    chk(rd, {24'h0, rh});
    rdr(CLO);
    chk(inr(rd, rl, rl + 60), 32'h1);
    wr(STA, 8'h03);
    rdr(CTL);
    chk(rd, 32'hc0);
    chk(irq, 1'b0);
    // Split: low byte free, high byte held, request masked then unmasked
    wr(MSK, 8'h00);
    wr(CTL, 8'h00);
    wr(CHI, 8'h55);
    wr(CLO, 8'hfe);
    wr(CTL, 8'h28);
    repeat (30) @(posedge aclk);
    wr(CTL, 8'h40);
    rdr(CTL);
    chk(rd, 32'h40);
    rdr(CHI);
    chk(rd, 32'h55);
    rdr(CLO);
    chk(inr(rd, rl, rl + 60), 32'h1);
    rdr(STA);
    chk(rd, 32'h2);
    chk(irq, 1'b0);
    wr(MSK, 8'h03);
    rdr(STA);
    chk(irq, 1'b1);
    wr(STA, 8'h03);
    wr(CTL, 8'h00);
    // Slow sources: divide by 12, external divided by 8, comparator edges
    wr(CKC, 8'h00);
    for (int m = 0; m < 3; m++) begin
      sel = (m == 0) ? (8'h04 | 8'($urandom_range(0, 1) * 2)) : ((m == 1) ? 8'h05 : 8'h07);
      wr(CLO, 8'h00);
      wr(CTL, sel);
      if (m == 0) repeat (240) @(posedge aclk);
      else pulses(m == 2, (m == 1) ? 24 : 5);
      repeat (8) @(posedge aclk);
      wr(CTL, 8'h00);
      rdr(CLO);
      n = (m == 0) ? 19 : 3 + 2 * (m - 1);
      chk(inr(rd, n, (m == 0) ? 22 : n), 1);
    end
    // Capture on a comparator rising edge
    wr(CKC, 8'h01);
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    wr(CTL, 8'h14);
    repeat (100) @(posedge aclk);
    cmp1_in <= 1'b1;
    wait_irq();
    wr(CTL, 8'h80);
    rdr(RLO);
    rl = rd[7:0];
    rdr(RHI);
    chk(inr({rd[7:0], rl}, 100, 115), 32'h1);
    rdr(CTL);
    chk(rd, 32'h80);
    // Capture on every eighth external edge with the upper select bit set
    wr(CTL, 8'h00);
    wr(STA, 8'h03);
    wr(CLO, 8'h00);
    wr(CHI, 8'h00);
    wr(CTL, 8'h16);
    pulses(1'b0, 8);
    wait_irq();
    wr(CTL, 8'h80);
    rdr(RLO);
    rl = rd[7:0];
    rdr(RHI);
    chk(inr({rd[7:0], rl}, 50, 60), 32'h1);
    wrap_up();
  end
endmodule
